// ===== bench/logger_mission_alarm_control_test.sv
// self-checking bench for the mission and alarm control block
`timescale 1ns/1ns
module logger_mission_alarm_control_test;
  logic clk_sys, sys_rst, wr_strobe, rd_strobe, sec_tick, conv_request, conv_wide;
  logic cmd_start_mission, cmd_stop_mission, cmd_force_conv, cmd_clear_memory;
  logic conv_valid, osc_enable, seconds_unit, mission_running, waiting_alarm, log_full, log_we;
  logic [15:0] addr, conv_result, log_addr, temp_value;
  logic [7:0] wr_data, rd_data, log_data;
  logic [13:0] sample_rate;
  logic [23:0] sample_count;
  int n_errors = 0;
  int n_compared = 0;
  mission_alarm_ctrl #(.LOG_BYTES(16)) mission_alarm_ctrl_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .cmd_start_mission(cmd_start_mission),
    .cmd_stop_mission(cmd_stop_mission), .cmd_force_conv(cmd_force_conv),
    .cmd_clear_memory(cmd_clear_memory), .sec_tick(sec_tick), .sample_rate(sample_rate),
    .conv_request(conv_request), .conv_wide(conv_wide), .conv_valid(conv_valid),
    .conv_result(conv_result), .osc_enable(osc_enable), .seconds_unit(seconds_unit),
    .mission_running(mission_running), .waiting_alarm(waiting_alarm), .log_full(log_full),
    .log_we(log_we), .log_addr(log_addr), .log_data(log_data), .sample_count(sample_count));
  temp_sensor_model temp_sensor_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .conv_request(conv_request), .temp_value(temp_value), .conv_valid(conv_valid),
    .conv_result(conv_result));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
    // let the write settle before anyone looks at the outputs
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample right there
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    #1;
    chk({16'h0000, rd_data}, {16'h0000, exp});
  endtask : rd
  // one command pulse: 0 force conversion, 1 start, 2 stop, 3 clear memory
  task automatic pulse(input int which);
    @(posedge clk_sys);
    cmd_force_conv <= (which == 0);
    cmd_start_mission <= (which == 1);
    cmd_stop_mission <= (which == 2);
    cmd_clear_memory <= (which == 3);
    @(posedge clk_sys);
    {cmd_force_conv, cmd_start_mission, cmd_stop_mission, cmd_clear_memory} <= 4'h0;
    #1;
  endtask : pulse
  // tick seconds for at most 40 cycles; got tells whether a log write showed up
  task automatic tick_log(input logic [15:0] t, output logic got);
    int i;
    temp_value = t;
    got = 1'b0;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk_sys);
      sec_tick <= (i % 8 == 0);
      #1;
      if (log_we === 1'b1)
      begin
        got = 1'b1;
        break;
      end
    end
  endtask : tick_log
  // tick seconds until one sample is logged, then check both stored bytes
  task automatic sample(input logic [15:0] t, input logic [15:0] ofs);
    logic got;
    tick_log(t, got);
    if (got !== 1'b1)
    begin
      n_errors++;
      stop_test();
    end
    chk({8'h00, log_addr}, {8'h00, 16'h1000 + ofs});
    chk({16'h0000, log_data}, {16'h0000, t[15:8]});
    @(posedge clk_sys);
    sec_tick <= 1'b0;
    #1;
    chk({8'h00, log_addr}, {8'h00, 16'h1001 + ofs});
    chk({16'h0000, log_data}, {16'h0000, t[7:0]});
  endtask : sample
  // alarm-triggered start: quiet samples wait, the trigger is logged uncounted, then fill
  task automatic scen_alarm_start();
    logic got;
    int k;
    pulse(3);
    wr(16'h0213, 8'h25);
    pulse(1);
    chk({23'h0, waiting_alarm}, 24'h00_0001);
    tick_log(16'h5000, got);
    chk({23'h0, got}, 24'h00_0000);
    chk({23'h0, conv_wide}, 24'h00_0000);
    sample(16'h9040, 16'h0000);
    chk({23'h0, waiting_alarm}, 24'h00_0000);
    chk(sample_count, 24'h00_0000);
    for (k = 1; k < 8; k++)
      sample(16'h5020, 16'(2 * k));
    chk({23'h0, log_full}, 24'h00_0001);
    chk(sample_count, 24'h00_0007);
    tick_log(16'h9000, got);
    chk({23'h0, got}, 24'h00_0000);
    chk({23'h0, mission_running}, 24'h00_0001);
    pulse(2);
  endtask : scen_alarm_start
  // rollover: the ninth 16-bit sample wraps to the start of a 16-byte log
  task automatic scen_rollover();
    int k;
    pulse(3);
    wr(16'h0213, 8'h15);
    pulse(1);
    for (k = 0; k < 9; k++)
      sample(16'h5020, 16'((2 * k) % 16));
    chk({23'h0, log_full}, 24'h00_0000);
    chk(sample_count, 24'h00_0009);
    pulse(2);
  endtask : scen_rollover
  // ************************************************************
  // clock, reset and main sequence
  // ************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    sys_rst = 1'b1;
    {wr_strobe, rd_strobe, sec_tick, cmd_start_mission, cmd_stop_mission} = 5'h00;
    {cmd_force_conv, cmd_clear_memory} = 2'h0;
    addr = 16'h0000;
    wr_data = 8'h00;
    sample_rate = 14'h0001;
    temp_value = 16'h0000;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(16'h0214, 8'hF0);
    rd(16'h0213, 8'hC0);
    rd(16'h0211, 8'h00);
    wr(16'h0210, 8'hFF);
    rd(16'h0210, 8'h03);
    wr(16'h0212, 8'hFE);
    rd(16'h0212, 8'h02);
    chk({23'h0, osc_enable}, 24'h00_0000);
    pulse(0);
    chk({23'h0, osc_enable}, 24'h00_0001);
    wr(16'h0212, 8'h02);
    chk({23'h0, seconds_unit}, 24'h00_0001);
    wr(16'h0213, 8'h3C);
    rd(16'h0213, 8'hFC);
    wr(16'h0213, 8'h05);
    rd(16'h0213, 8'hC5);
    wr(16'h0208, 8'h20);
    wr(16'h0209, 8'h80);
    rd(16'h0208, 8'h20);
    rd(16'h0209, 8'h80);
    pulse(1);
    chk({22'h0, mission_running, osc_enable}, 24'h00_0003);
    wr(16'h0210, 8'h00);
    rd(16'h0210, 8'h03);
    sample(16'h8060, 16'h0000);
    rd(16'h0214, 8'hF2);
    sample(16'h20FF, 16'h0002);
    rd(16'h0214, 8'hF3);
    chk(sample_count, 24'h00_0002);
    pulse(3);
    rd(16'h0214, 8'h70);
    pulse(2);
    chk({23'h0, mission_running}, 24'h00_0000);
    scen_alarm_start();
    scen_rollover();
    stop_test();
  end
endmodule : logger_mission_alarm_control_test

// ===== bench/temp_sensor_model.sv
// behavioural temperature sensor answering conversion requests
`timescale 1ns/1ns
module temp_sensor_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic conv_request,
  input wire logic [15:0] temp_value,
  output logic conv_valid,
  output logic [15:0] conv_result
);
  logic [2:0] dly_reg;
  // answer three cycles after a request; the result bus scrambles once its pulse is over
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dly_reg <= 3'h0;
      conv_valid <= 1'b0;
      conv_result <= 16'h0000;
    end
    else
    begin
      conv_valid <= 1'b0;
      if (conv_request)
        dly_reg <= 3'h3;
      else if (dly_reg != 3'h0)
        dly_reg <= dly_reg - 3'h1;
      if (dly_reg == 3'h1)
      begin
        conv_valid <= 1'b1;
        conv_result <= temp_value;
      end
      else
        conv_result <= ~conv_result; // no stale value for the block to lean on
    end
  end
endmodule : temp_sensor_model

// ===== rtl/mission_alarm_ctrl.sv
// mission configuration, alarm thresholds and alarm status of a temperature logger
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "mission_alarm_params.svh"
module mission_alarm_ctrl #(
  parameter int LOG_BYTES = 8192
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  input wire logic cmd_start_mission,
  input wire logic cmd_stop_mission,
  input wire logic cmd_force_conv,
  input wire logic cmd_clear_memory,
  input wire logic sec_tick,
  input wire logic [13:0] sample_rate,
  output logic conv_request,
  output logic conv_wide,
  input wire logic conv_valid,
  input wire logic [15:0] conv_result,
  output logic osc_enable,
  output logic seconds_unit,
  output logic mission_running,
  output logic waiting_alarm,
  output logic log_full,
  output logic log_we,
  output logic [15:0] log_addr,
  output logic [7:0] log_data,
  output logic [23:0] sample_count
);
  import mission_alarm_pkg::*;

  mission_alarm_pkg::state_t st_reg;
  mission_alarm_pkg::state_t st_next;
  logic [7:0] msb;
  logic hi_hit;
  logic lo_hit;
  logic unit_tick;
  logic [13:0] rate_eff;
  logic [13:0] ptr_sum;
  logic do_log;

  // ****************************************
  // register read decode
  // ****************************************
  function automatic logic [7:0] read_mux(input state_t s, input logic [15:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `ADDR_THR_LOW: d = s.thr_lo;
      `ADDR_THR_HIGH: d = s.thr_hi;
      `ADDR_SENSOR_CTL: d = {6'h00, s.hi_en, s.lo_en};
      `ADDR_OSC_CTL: d = {6'h00, s.secs, s.osc_en};
      `ADDR_MISSION_SETUP:
        d = `MC_FIXED_ONES | {2'b00, s.start_upon_alarm, s.ro, s.spare, s.logging_format_select, 1'b0, s.logging_enable};
      `ADDR_ALARM_FLAGS:
        d = `AF_FIXED_ONES | {s.flag_bor, 5'h00, s.flag_hi, s.flag_lo};
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_mux

  // ****************************************
  // alarm compare and interval timing
  // ****************************************
  // only the high byte matters, so 8-bit and 16-bit modes alarm alike
  assign msb = conv_result[15:8];
  assign hi_hit = st_reg.hi_en && (msb >= st_reg.thr_hi);
  assign lo_hit = st_reg.lo_en && (msb <= st_reg.thr_lo);
  // minutes are built from sixty second ticks
  assign unit_tick = sec_tick && (st_reg.secs || st_reg.sec_cnt == `SEC_LAST);
  // a rate of zero behaves as one
  assign rate_eff = (sample_rate == 14'h0000) ? 14'h0001 : sample_rate;
  assign ptr_sum = {1'b0, st_reg.ptr} + (st_reg.logging_format_select ? 14'h0002 : 14'h0001);
  // a sample is stored when logging is armed, the log still has room and no alarm wait is pending or the sample alarms
  assign do_log = conv_valid && st_reg.mission && st_reg.osc_en && st_reg.logging_enable
                  && !st_reg.full && (!st_reg.waiting || hi_hit || lo_hit);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.log_we = 1'b0;
    st_next.conv_req = 1'b0;
    st_next.rd_data = rd_strobe ? read_mux(st_reg, addr) : 8'h00;
    // configuration writes, locked while a mission runs
    if (wr_strobe && !st_reg.mission)
    begin
      case (addr)
        `ADDR_THR_LOW: st_next.thr_lo = wr_data;
        `ADDR_THR_HIGH: st_next.thr_hi = wr_data;
        `ADDR_SENSOR_CTL:
        begin
          st_next.hi_en = wr_data[`BIT_HI_EN];
          st_next.lo_en = wr_data[`BIT_LO_EN];
        end
        `ADDR_OSC_CTL:
        begin
          st_next.secs = wr_data[`BIT_SECS];
          st_next.osc_en = wr_data[`BIT_OSC];
        end
        `ADDR_MISSION_SETUP:
        begin
          // bit 1 is not stored; the host keeps it at zero
          st_next.start_upon_alarm = wr_data[`BIT_START_UPON_ALARM];
          st_next.ro = wr_data[`BIT_RO];
          st_next.spare = wr_data[`BIT_SPARE];
          st_next.logging_format_select = wr_data[`BIT_LOGGING_FORMAT_SELECT];
          st_next.logging_enable = wr_data[`BIT_ETL];
        end
        default: st_next.thr_lo = st_reg.thr_lo;
      endcase
    end
    // mission commands
    if (cmd_force_conv)
    begin
      st_next.osc_en = 1'b1;
    end
    if (cmd_start_mission && !st_reg.mission)
    begin
      st_next.osc_en = 1'b1;
      st_next.mission = 1'b1;
      st_next.waiting = st_reg.start_upon_alarm;
      st_next.full = 1'b0;
      st_next.ptr = 13'h0000;
      st_next.sec_cnt = 6'd0;
      st_next.intv_cnt = 14'h0000;
    end
    if (cmd_stop_mission)
    begin
      st_next.mission = 1'b0;
    end
    // clear memory resets flags and count; a same-cycle alarm below still wins
    if (cmd_clear_memory)
    begin
      st_next.flag_hi = 1'b0;
      st_next.flag_lo = 1'b0;
      st_next.flag_bor = 1'b0;
      st_next.count = `RST_COUNT;
    end
    // interval counter runs only with the oscillator on and room left
    if (st_reg.mission && st_reg.osc_en && !st_reg.full)
    begin
      if (sec_tick)
      begin
        st_next.sec_cnt = (st_reg.sec_cnt == `SEC_LAST) ? 6'd0 : st_reg.sec_cnt + 6'd1;
      end
      if (unit_tick)
      begin
        if (st_reg.intv_cnt + 14'h0001 >= rate_eff)
        begin
          st_next.intv_cnt = 14'h0000;
          st_next.conv_req = 1'b1;
        end
        else
        begin
          st_next.intv_cnt = st_reg.intv_cnt + 14'h0001;
        end
      end
    end
    // alarm flags are sticky; they never clear on a quiet sample
    if (conv_valid && st_reg.mission && st_reg.osc_en)
    begin
      if (hi_hit)
      begin
        st_next.flag_hi = 1'b1;
      end
      if (lo_hit)
      begin
        st_next.flag_lo = 1'b1;
      end
    end
    // second byte of a 16-bit sample goes one address above the first
    case (st_reg.phase)
      WR_SECOND:
      begin
        st_next.log_we = 1'b1;
        st_next.log_addr = st_reg.log_addr + 16'h0001;
        st_next.log_data = st_reg.lo_byte;
        st_next.phase = WR_IDLE;
      end
      default: st_next.phase = WR_IDLE;
    endcase
    // store a sample, high byte at the lower address
    if (do_log)
    begin
      st_next.log_we = 1'b1;
      st_next.log_addr = `LOG_BASE + {3'b000, st_reg.ptr};
      st_next.log_data = msb;
      st_next.lo_byte = conv_result[7:0];
      st_next.phase = st_reg.logging_format_select ? WR_SECOND : WR_IDLE;
      st_next.waiting = 1'b0;
      if (!st_reg.waiting)
      begin
        st_next.count = st_next.count + 24'h00_0001;
      end
      if (ptr_sum >= LOG_BYTES[13:0])
      begin
        st_next.ptr = 13'h0000;
        st_next.full = !st_reg.ro;
      end
      else
      begin
        st_next.ptr = ptr_sum[12:0];
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // power-on reset leaves the battery reset flag set
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.flag_bor <= 1'b1;
      st_reg.phase <= WR_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_data = st_reg.rd_data;
  assign conv_request = st_reg.conv_req;
  // alarm-wait conversions are always 8-bit
  assign conv_wide = st_reg.logging_format_select && !st_reg.waiting;
  assign osc_enable = st_reg.osc_en;
  assign seconds_unit = st_reg.secs;
  assign mission_running = st_reg.mission;
  assign waiting_alarm = st_reg.waiting;
  assign log_full = st_reg.full;
  assign log_we = st_reg.log_we;
  assign log_addr = st_reg.log_addr;
  assign log_data = st_reg.log_data;
  assign sample_count = st_reg.count;

  // ****************************************
  // assertions
  // ****************************************
  a_sensor_zero_bits: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_strobe && addr == `ADDR_SENSOR_CTL |=> rd_data[7:2] == 6'h00)
    else $error("sensor control upper bits not zero");
  a_setup_one_bits: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_strobe && addr == `ADDR_MISSION_SETUP |=> rd_data[7:6] == 2'b11)
    else $error("mission setup upper bits not one");
  a_flags_fixed_bits: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_strobe && addr == `ADDR_ALARM_FLAGS |=> rd_data[6:2] == 5'b11100)
    else $error("alarm flags fixed bits wrong");
  a_mission_lock: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.mission && wr_strobe |=> $stable({st_reg.start_upon_alarm, st_reg.logging_format_select, st_reg.hi_en, st_reg.secs}))
    else $error("write took effect during mission");
  a_high_alarm_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_valid && st_reg.mission && st_reg.osc_en && st_reg.hi_en && msb >= st_reg.thr_hi
    |=> st_reg.flag_hi)
    else $error("high alarm flag not set");
  a_low_alarm_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_valid && st_reg.mission && st_reg.osc_en && st_reg.lo_en && msb <= st_reg.thr_lo
    |=> st_reg.flag_lo)
    else $error("low alarm flag not set");
  a_alarm_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.flag_hi && !cmd_clear_memory |=> st_reg.flag_hi)
    else $error("high alarm flag dropped");
  a_osc_auto_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_force_conv || cmd_start_mission |=> osc_enable)
    else $error("oscillator not started by command");
  a_full_stops: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.full |=> !conv_request && !(log_we && st_reg.phase == WR_IDLE && !$past(log_we)))
    else $error("activity after log full");
  a_wide_msb_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    do_log && st_reg.logging_format_select |=> log_we ##1 log_we && log_addr == $past(log_addr) + 16'h0001)
    else $error("16-bit sample not stored high byte first");
  a_trigger_no_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    do_log && st_reg.waiting && !cmd_clear_memory |=> $stable(sample_count) && log_we)
    else $error("trigger sample counted or not logged");
endmodule : mission_alarm_ctrl

// ===== rtl/mission_alarm_params.svh
// constants for the mission and alarm control block
`ifndef MISSION_ALARM_PARAMS_SVH
`define MISSION_ALARM_PARAMS_SVH
// register offsets
`define ADDR_THR_LOW 16'h0208
`define ADDR_THR_HIGH 16'h0209
`define ADDR_SENSOR_CTL 16'h0210
`define ADDR_OSC_CTL 16'h0212
`define ADDR_MISSION_SETUP 16'h0213
`define ADDR_ALARM_FLAGS 16'h0214
// first byte of the data-log area
`define LOG_BASE 16'h1000
// field positions
`define BIT_HI_EN 1
`define BIT_LO_EN 0
`define BIT_SECS 1
`define BIT_OSC 0
`define BIT_START_UPON_ALARM 5
`define BIT_RO 4
`define BIT_SPARE 3
`define BIT_LOGGING_FORMAT_SELECT 2
`define BIT_ETL 0
`define BIT_HI_FLAG 1
`define BIT_LO_FLAG 0
`define BIT_BOR 7
// fixed bit patterns seen on reads
`define MC_FIXED_ONES 8'hC0
`define AF_FIXED_ONES 8'h70
// reset values
`define RST_BYTE 8'h00
`define RST_COUNT 24'h00_0000
// seconds per minute, as a terminal count
`define SEC_LAST 6'd59
`endif

// ===== rtl/mission_alarm_pkg.sv
// types of the mission and alarm control block
package mission_alarm_pkg;
  // data-log write phase; the second phase writes the low byte of a 16-bit sample
  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_SECOND = 1'b1} wr_phase_t;

  typedef struct packed {
    logic [7:0] thr_lo;
    logic [7:0] thr_hi;
    logic hi_en;
    logic lo_en;
    logic osc_en;
    logic secs;
    logic start_upon_alarm;
    logic ro;
    logic spare;
    logic logging_format_select;
    logic logging_enable;
    logic flag_hi;
    logic flag_lo;
    logic flag_bor;
    logic mission;
    logic waiting;
    logic full;
    logic [12:0] ptr;
    logic [23:0] count;
    logic [5:0] sec_cnt;
    logic [13:0] intv_cnt;
    logic conv_req;
    wr_phase_t phase;
    logic [7:0] lo_byte;
    logic log_we;
    logic [15:0] log_addr;
    logic [7:0] log_data;
    logic [7:0] rd_data;
  } state_t;
endpackage : mission_alarm_pkg
